/* hw/ucp_regs.svh */
// constants and reset values of the cell link and requester number block
`ifndef UCP_REGS_SVH
`define UCP_REGS_SVH

`define UCP_CELL_LEN 6'h35
`define UCP_CELL_LAST 6'h34
`define UCP_IDLE_ZERO 8'h00
`define UCP_IDLE_HDR3 8'h01
`define UCP_IDLE_HEC 8'h52
`define UCP_IDLE_FILL 8'h6A
`define UCP_IDX_HDR3 6'h03
`define UCP_IDX_HEC 6'h04
`define UCP_DIR_BIT 5
`define UCP_SUB_MSB 4
`define UCP_TARGET_BIT 8
`define UCP_REQ_RESET 6'h00

`endif

/* hw/ucp_pkg.sv */
// types shared by the cell link modules
package ucp_pkg;
  typedef enum logic [1:0] {UCP_MODE_SLAVE, UCP_MODE_MASTER, UCP_MODE_MULTI_PHY, UCP_MODE_MII} ucp_mode_t;
  typedef enum logic [1:0] {UCP_SLV_LOAD, UCP_SLV_READY, UCP_SLV_SEND} ucp_slave_state_t;
  typedef enum logic {UCP_MST_IDLE, UCP_MST_RECV} ucp_master_state_t;
endpackage

/* hw/ucp_xfer_if.sv */
// octet carrier from the crossing into the link domain
`timescale 1ns/100ps
interface ucp_xfer_if;
  logic valid;
  logic ready;
  logic [8:0] data;
  modport dst (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hw/ucp_cell_mem.sv */
// one cell of octet storage with registered read
`timescale 1ns/100ps
`include "ucp_regs.svh"
module ucp_cell_mem import ucp_pkg::*; (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [5:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [5:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] store [0:52];

  always_ff @(posedge clk)
  begin
    if (wrEn)
      store[wrAddr] <= wrData;
  end

  always_ff @(posedge clk)
  begin
    rdData <= store[rdAddr];
  end
endmodule

/* hw/ucp_xfer_cross.sv */
// toggle handshake carrying one tagged octet from the system clock to the link clock
`timescale 1ns/100ps
module ucp_xfer_cross import ucp_pkg::*; (
  input wire logic srcClk,
  input wire logic srcReset_n,
  input wire logic srcValid,
  input wire logic [8:0] srcData,
  output logic srcReady,
  input wire logic dstClk,
  input wire logic dstReset_n,
  ucp_xfer_if.dst link
);
  logic reqTgl;
  logic ackS1;
  logic ackS2;
  logic [8:0] hold;
  logic next_reqTgl;
  logic reqS1;
  logic reqS2;
  logic ackTgl;

  assign next_reqTgl = reqTgl ^ (srcValid & srcReady);

  always_ff @(posedge srcClk)
  begin
    if (!srcReset_n)
    begin
      reqTgl <= 1'b0;
      ackS1 <= 1'b0;
      ackS2 <= 1'b0;
      srcReady <= 1'b0;
      hold <= 9'h000;
    end
    else
    begin
      ackS1 <= ackTgl;
      ackS2 <= ackS1;
      reqTgl <= next_reqTgl;
      // ready is registered so it can feed a top-level output directly
      srcReady <= (next_reqTgl == ackS2);
      if (srcValid && srcReady)
        hold <= srcData;
    end
  end

  // hold is stable for two link edges before the request toggle is seen
  always_ff @(posedge dstClk)
  begin
    if (!dstReset_n)
    begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      ackTgl <= 1'b0;
    end
    else
    begin
      reqS1 <= reqTgl;
      reqS2 <= reqS1;
      if (link.valid && link.ready)
        ackTgl <= ~ackTgl;
    end
  end

  assign link.valid = (reqS2 != ackTgl);
  assign link.data = hold;
endmodule

/* hw/ucp_atm_mii_pins.sv */
// cell link pins: slave receive, master receive, transmit with idle cells, mii flags, requester number
`timescale 1ns/100ps
`include "ucp_regs.svh"
module ucp_atm_mii_pins import ucp_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic linkClk,
  input wire logic linkReset_n,
  input wire logic [1:0] mode,
  input wire logic [7:0] cellByte,
  input wire logic cellToTransmit,
  input wire logic cellByteValid,
  output logic cellByteReady,
  input wire logic rxEnableIn_n,
  output logic rxEnableOut_n,
  output logic rxEnableOe_n,
  input wire logic rxClavIn,
  output logic rxClavOut,
  output logic rxClavOe_n,
  input wire logic [3:1] polledPhyCellReady,
  input wire logic [7:0] rxDataIn,
  output logic [7:0] rxDataOut,
  output logic rxDataOe_n,
  input wire logic rxSocIn,
  output logic rxSocOut,
  output logic rxSocOe_n,
  output logic [7:0] txData,
  output logic txSoc,
  input wire logic rxDv,
  input wire logic rxEr,
  input wire logic carrierSense,
  output logic miiBrokenHeader,
  output logic miiRxError,
  output logic masterCellDone,
  output logic masterSocError,
  output logic [1:0] masterPhy,
  input wire logic dmaActive,
  input wire logic [4:0] dmaSubBlock,
  input wire logic dmaReceive,
  input wire logic dmaError,
  output logic [5:0] dmaRequesterNumber,
  output logic [5:0] dmaErrorRecord
);
  function automatic logic [5:0] ucpNextIdx(input logic [5:0] idx);
    ucpNextIdx = (idx == `UCP_CELL_LAST) ? 6'h00 : idx + 6'h01;
  endfunction

  function automatic logic [7:0] ucpIdleByte(input logic [5:0] idx);
    if (idx < `UCP_IDX_HDR3)
      ucpIdleByte = `UCP_IDLE_ZERO;
    else if (idx == `UCP_IDX_HDR3)
      ucpIdleByte = `UCP_IDLE_HDR3;
    else if (idx == `UCP_IDX_HEC)
      ucpIdleByte = `UCP_IDLE_HEC;
    else
      ucpIdleByte = `UCP_IDLE_FILL;
  endfunction

  ucp_xfer_if xf();
  logic [1:0] modeS1;
  logic [1:0] modeS2;
  ucp_mode_t linkMode;
  ucp_slave_state_t slvState;
  logic [5:0] slvWrIdx;
  logic [5:0] slvRdIdx;
  logic [7:0] slvRd;
  logic slvHit;
  logic slvWr;
  logic [5:0] txIdx;
  logic [5:0] txWrIdx;
  logic txLoaded;
  logic txFromCell;
  logic txDataFromCell;
  logic [7:0] txRd;
  logic txWr;
  ucp_master_state_t mstState;
  logic [1:0] mstPhy;
  logic [5:0] mstEnCount;
  logic [5:0] mstSmpCount;
  logic mstEnPrev;
  logic mstSocBad;
  logic mstDoneTgl;
  logic [1:0] mstPhyHold;
  logic mstSocBadHold;
  logic [3:0] readyVec;
  logic phyReady;
  logic isMaster;
  logic miiBrokenLink;
  logic miiErrLink;
  logic brokenS1;
  logic errS1;
  logic doneS1;
  logic doneS2;
  logic doneS3;

  // user octets cross into the link domain tagged with their target cell
  ucp_xfer_cross u_cross (
    .srcClk(clk),
    .srcReset_n(reset_n),
    .srcValid(cellByteValid),
    .srcData({cellToTransmit, cellByte}),
    .srcReady(cellByteReady),
    .dstClk(linkClk),
    .dstReset_n(linkReset_n),
    .link(xf.dst)
  );

  // mode is a quasi-static level; change it only while the link is quiet
  always_ff @(posedge linkClk)
  begin
    if (!linkReset_n)
    begin
      modeS1 <= 2'h0;
      modeS2 <= 2'h0;
    end
    else
    begin
      modeS1 <= mode;
      modeS2 <= modeS1;
    end
  end

  assign linkMode = ucp_mode_t'(modeS2);
  assign isMaster = (linkMode == UCP_MODE_MASTER) || (linkMode == UCP_MODE_MULTI_PHY);
  assign xf.ready = xf.data[`UCP_TARGET_BIT] ? !txLoaded : (slvState == UCP_SLV_LOAD);
  assign slvWr = xf.valid && xf.ready && !xf.data[`UCP_TARGET_BIT];
  assign txWr = xf.valid && xf.ready && xf.data[`UCP_TARGET_BIT];
  assign slvHit = (linkMode == UCP_MODE_SLAVE) && (slvState != UCP_SLV_LOAD) && !rxEnableIn_n;

  ucp_cell_mem u_rxCell (
    .clk(linkClk),
    .wrEn(slvWr),
    .wrAddr(slvWrIdx),
    .wrData(xf.data[7:0]),
    .rdAddr(slvHit ? ucpNextIdx(slvRdIdx) : slvRdIdx),
    .rdData(slvRd)
  );

  ucp_cell_mem u_txCell (
    .clk(linkClk),
    .wrEn(txWr),
    .wrAddr(txWrIdx),
    .wrData(xf.data[7:0]),
    .rdAddr(ucpNextIdx(txIdx)),
    .rdData(txRd)
  );

  // slave receive cell: load 53 octets, offer, then send one per enable
  always_ff @(posedge linkClk)
  begin
    if (!linkReset_n)
    begin
      slvState <= UCP_SLV_LOAD;
      slvWrIdx <= 6'h00;
      slvRdIdx <= 6'h00;
    end
    else
    begin
      case (slvState)
        UCP_SLV_LOAD:
        begin
          if (slvWr)
          begin
            slvWrIdx <= slvWrIdx + 6'h01;
            if (slvWrIdx == `UCP_CELL_LAST)
              slvState <= UCP_SLV_READY;
          end
        end
        UCP_SLV_READY, UCP_SLV_SEND:
        begin
          if (slvHit)
          begin
            slvRdIdx <= ucpNextIdx(slvRdIdx);
            slvState <= UCP_SLV_SEND;
            if (slvRdIdx == `UCP_CELL_LAST)
            begin
              slvState <= UCP_SLV_LOAD;
              slvWrIdx <= 6'h00;
            end
          end
        end
        default:
          slvState <= UCP_SLV_LOAD;
      endcase
    end
  end

  // slave pin drivers; data floats unless the previous cycle carried an enable
  always_ff @(posedge linkClk)
  begin
    if (!linkReset_n)
    begin
      rxDataOut <= 8'h00;
      rxDataOe_n <= 1'b1;
      rxSocOut <= 1'b0;
      rxSocOe_n <= 1'b1;
      rxClavOut <= 1'b0;
      rxClavOe_n <= 1'b1;
    end
    else
    begin
      rxDataOut <= slvHit ? slvRd : 8'h00;
      rxDataOe_n <= !slvHit;
      rxSocOe_n <= !slvHit;
      rxSocOut <= slvHit && (slvRdIdx == 6'h00);
      rxClavOut <= (linkMode == UCP_MODE_SLAVE) && (slvState == UCP_SLV_READY) && !slvHit;
      rxClavOe_n <= (linkMode != UCP_MODE_SLAVE);
    end
  end

  // transmit side runs continuously, one octet per link cycle
  always_ff @(posedge linkClk)
  begin
    if (!linkReset_n)
    begin
      txIdx <= 6'h00;
      txWrIdx <= 6'h00;
      txLoaded <= 1'b0;
      txFromCell <= 1'b0;
      txDataFromCell <= 1'b0;
      txData <= 8'h00;
      txSoc <= 1'b0;
    end
    else
    begin
      txIdx <= ucpNextIdx(txIdx);
      txSoc <= (txIdx == 6'h00);
      txDataFromCell <= txFromCell;
      txData <= txFromCell ? txRd : ucpIdleByte(txIdx);
      if (txWr)
      begin
        txWrIdx <= ucpNextIdx(txWrIdx);
        if (txWrIdx == `UCP_CELL_LAST)
          txLoaded <= 1'b1;
      end
      if (txIdx == `UCP_CELL_LAST)
      begin
        txFromCell <= txLoaded && !txFromCell;
        if (txFromCell)
        begin
          txLoaded <= 1'b0;
          txWrIdx <= 6'h00;
        end
      end
    end
  end

  assign readyVec = {polledPhyCellReady, rxClavIn};
  assign phyReady = (linkMode == UCP_MODE_MULTI_PHY) ? readyVec[mstPhy] : rxClavIn;

  // master receive: enable 53 cycles, sample soc of each octet one cycle later
  always_ff @(posedge linkClk)
  begin
    if (!linkReset_n)
    begin
      mstState <= UCP_MST_IDLE;
      mstPhy <= 2'h0;
      mstEnCount <= 6'h00;
      mstSmpCount <= 6'h00;
      mstEnPrev <= 1'b0;
      mstSocBad <= 1'b0;
      mstDoneTgl <= 1'b0;
      mstPhyHold <= 2'h0;
      mstSocBadHold <= 1'b0;
      rxEnableOut_n <= 1'b1;
      rxEnableOe_n <= 1'b1;
    end
    else
    begin
      rxEnableOe_n <= !isMaster;
      mstEnPrev <= !rxEnableOut_n;
      case (mstState)
        UCP_MST_IDLE:
        begin
          if (isMaster && phyReady)
          begin
            rxEnableOut_n <= 1'b0;
            mstEnCount <= 6'h01;
            mstSmpCount <= 6'h00;
            mstSocBad <= 1'b0;
            mstState <= UCP_MST_RECV;
          end
          else if (linkMode == UCP_MODE_MULTI_PHY)
            mstPhy <= mstPhy + 2'h1;
        end
        UCP_MST_RECV:
        begin
          if (mstEnCount == `UCP_CELL_LEN)
            rxEnableOut_n <= 1'b1;
          else
            mstEnCount <= mstEnCount + 6'h01;
          if (mstEnPrev)
          begin
            mstSmpCount <= mstSmpCount + 6'h01;
            if (rxSocIn != (mstSmpCount == 6'h00))
              mstSocBad <= 1'b1;
            if (mstSmpCount == `UCP_CELL_LAST)
            begin
              mstDoneTgl <= ~mstDoneTgl;
              mstPhyHold <= mstPhy;
              mstSocBadHold <= mstSocBad || (rxSocIn != (mstSmpCount == 6'h00));
              mstState <= UCP_MST_IDLE;
              if (linkMode == UCP_MODE_MULTI_PHY)
                mstPhy <= mstPhy + 2'h1;
            end
          end
        end
        default:
          mstState <= UCP_MST_IDLE;
      endcase
    end
  end

  // mii status, sampled on the receive clock
  always_ff @(posedge linkClk)
  begin
    if (!linkReset_n)
    begin
      miiBrokenLink <= 1'b0;
      miiErrLink <= 1'b0;
    end
    else
    begin
      miiBrokenLink <= (linkMode == UCP_MODE_MII) && carrierSense && !rxDv;
      miiErrLink <= (linkMode == UCP_MODE_MII) && rxDv && rxEr;
    end
  end

  // link status back to the system clock
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      brokenS1 <= 1'b0;
      errS1 <= 1'b0;
      miiBrokenHeader <= 1'b0;
      miiRxError <= 1'b0;
      doneS1 <= 1'b0;
      doneS2 <= 1'b0;
      doneS3 <= 1'b0;
      masterCellDone <= 1'b0;
      masterSocError <= 1'b0;
      masterPhy <= 2'h0;
    end
    else
    begin
      brokenS1 <= miiBrokenLink;
      miiBrokenHeader <= brokenS1;
      errS1 <= miiErrLink;
      miiRxError <= errS1;
      doneS1 <= mstDoneTgl;
      doneS2 <= doneS1;
      doneS3 <= doneS2;
      masterCellDone <= doneS2 ^ doneS3;
      // hold values stand for a whole cell after the toggle, so they are settled here
      if (doneS2 ^ doneS3)
      begin
        masterPhy <= mstPhyHold;
        masterSocError <= mstSocBadHold;
      end
    end
  end

  // requester number and transfer error record
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dmaRequesterNumber <= `UCP_REQ_RESET;
      dmaErrorRecord <= `UCP_REQ_RESET;
    end
    else
    begin
      if (dmaActive)
        dmaRequesterNumber <= {dmaReceive, dmaSubBlock};
      if (dmaActive && dmaError)
        dmaErrorRecord <= {dmaReceive, dmaSubBlock};
    end
  end

  sequence s_idle_header;
    txData == 8'h00 ##1 txData == 8'h00 ##1 txData == 8'h00 ##1 txData == 8'h01 ##1 txData == 8'h52;
  endsequence

  property p_soc_first;
    @(posedge linkClk) disable iff (!linkReset_n)
    rxSocOut |-> !rxDataOe_n && slvRdIdx == 6'h01 && $past(!rxEnableIn_n);
  endproperty
  a_soc_first: assert property (p_soc_first) else $error("soc not on first octet");

  property p_clav_full;
    @(posedge linkClk) disable iff (!linkReset_n)
    rxClavOut |-> slvWrIdx == 6'h35;
  endproperty
  a_clav_full: assert property (p_clav_full) else $error("clav without whole cell");

  property p_poll_own;
    @(posedge linkClk) disable iff (!linkReset_n)
    ($fell(rxEnableOut_n) && linkMode == UCP_MODE_MULTI_PHY) |-> $past(readyVec[mstPhy]);
  endproperty
  a_poll_own: assert property (p_poll_own) else $error("enable without polled ready");

  property p_mii_broken;
    @(posedge linkClk) disable iff (!linkReset_n)
    miiBrokenLink |-> $past(carrierSense) && !$past(rxDv);
  endproperty
  a_mii_broken: assert property (p_mii_broken) else $error("broken header flag wrong");

  property p_idle_cell;
    @(posedge linkClk) disable iff (!linkReset_n)
    (txSoc && !txDataFromCell) |-> s_idle_header ##1 txData == 8'h6A;
  endproperty
  a_idle_cell: assert property (p_idle_cell) else $error("idle cell header wrong");

  property p_tx_period;
    @(posedge linkClk) disable iff (!linkReset_n)
    txSoc |=> !txSoc[*8] ##45 txSoc;
  endproperty
  a_tx_period: assert property (p_tx_period) else $error("cell is not 53 octets");

  property p_req_number;
    @(posedge clk) disable iff (!reset_n)
    dmaActive |=> dmaRequesterNumber[5] == $past(dmaReceive) && dmaRequesterNumber[4:0] == $past(dmaSubBlock);
  endproperty
  a_req_number: assert property (p_req_number) else $error("requester number wrong");

  property p_err_record;
    @(posedge clk) disable iff (!reset_n)
    (dmaActive && dmaError) |=> dmaErrorRecord == {$past(dmaReceive), $past(dmaSubBlock)};
  endproperty
  a_err_record: assert property (p_err_record) else $error("error record not captured");

  property p_float;
    @(posedge linkClk) disable iff (!linkReset_n)
    !rxDataOe_n |-> $past(!rxEnableIn_n) && $past(linkMode == UCP_MODE_SLAVE);
  endproperty
  a_float: assert property (p_float) else $error("data driven without enable");

  property p_mst_len;
    @(posedge linkClk) disable iff (!linkReset_n)
    $changed(mstDoneTgl) |-> $past(mstSmpCount) == 6'h34 && $past(mstEnPrev);
  endproperty
  a_mst_len: assert property (p_mst_len) else $error("master cell length wrong");
endmodule

/* test/ucp_far_phy.sv */
// far side model: utopia phy holding one cell at a time, plus mii phy lines
`timescale 1ns/100ps
module ucp_far_phy (
  input wire logic linkClk,
  input wire logic enable_n,
  input wire logic offer,
  input wire logic [1:0] phy,
  input wire logic badSoc,
  input wire logic [2:0] mii,
  output logic clav0,
  output logic [3:1] polled,
  output logic [7:0] data = 8'h00,
  output logic soc = 1'b0,
  output logic crs = 1'b0,
  output logic dv = 1'b0,
  output logic er = 1'b0
);
  logic held = 1'b0;
  logic spent = 1'b0;
  logic [5:0] cnt = 6'h00;
  // ready only with a whole cell, on its own line
  assign clav0 = held && phy == 2'd0;
  assign polled = held ? 3'((4'h1 << phy) >> 1) : 3'h0;
  always @(posedge linkClk)
  begin
    if (!offer)
    begin
      spent <= 1'b0;
    end
    if (offer && !held && !spent && cnt == 6'h00)
    begin
      held <= 1'b1;
    end
    // one octet in the cycle after each enable, 53 a cell
    if (!enable_n && (held || cnt != 6'h00))
    begin
      held <= 1'b0;
      data <= 8'h40 + 8'(cnt);
      soc <= (cnt == 6'h00) ^ badSoc;
      cnt <= cnt == 6'h34 ? 6'h00 : cnt + 6'h01;
      spent <= cnt == 6'h34;
    end
    else
    begin
      // released lines wander so a stray sample shows
      data <= ~data;
      soc <= ~soc;
    end
    // valid and error come from the commanded line state
    {crs, dv, er} <= mii;
  end
endmodule

/* test/testbench.sv */
// self-checking bench for the cell link pins block
`timescale 1ns/100ps
module testbench import ucp_pkg::*; ;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic reset_n = 1'b0;
  logic linkReset_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] cellByte = 8'h00;
  logic cellToTransmit = 1'b0, cellByteValid = 1'b0, tbEnable_n = 1'b1;
  logic dmaActive = 1'b0, dmaReceive = 1'b0, dmaError = 1'b0;
  logic [4:0] dmaSubBlock = 5'h00;
  logic offer = 1'b0, badSoc = 1'b0;
  logic [1:0] phy = 2'h0;
  logic [2:0] mii = 3'h0;
  logic cellByteReady, rxEnableOut_n, rxEnableOe_n, rxClavOut, rxClavOe_n, rxDataOe_n;
  logic rxSocOut, rxSocOe_n, txSoc, miiBrokenHeader, miiRxError, masterCellDone, masterSocError;
  logic [7:0] rxDataOut, txData, farData;
  logic [1:0] masterPhy;
  logic [5:0] dmaRequesterNumber, dmaErrorRecord, lastErr;
  logic farClav, farSoc, rxDv, rxEr, carrierSense;
  logic [3:1] polledPhyCellReady;
  logic [7:0] cellBuf [53];
  int n_mismatch = 0;
  int num_checks = 0;
  // shared wires resolve from whichever party has its enable low
  wire rxEnableIn_n = rxEnableOe_n ? tbEnable_n : rxEnableOut_n;
  wire rxClavIn = rxClavOe_n ? farClav : rxClavOut;
  wire [7:0] rxDataIn = rxDataOe_n ? farData : rxDataOut;
  wire rxSocIn = rxSocOe_n ? farSoc : rxSocOut;

  ucp_atm_mii_pins ucp_atm_mii_pins_inst (.clk(clk), .reset_n(reset_n), .linkClk(linkClk),
    .linkReset_n(linkReset_n), .mode(mode), .cellByte(cellByte), .cellToTransmit(cellToTransmit),
    .cellByteValid(cellByteValid), .cellByteReady(cellByteReady), .rxEnableIn_n(rxEnableIn_n),
    .rxEnableOut_n(rxEnableOut_n), .rxEnableOe_n(rxEnableOe_n), .rxClavIn(rxClavIn), .rxClavOut(rxClavOut),
    .rxClavOe_n(rxClavOe_n), .polledPhyCellReady(polledPhyCellReady), .rxDataIn(rxDataIn),
    .rxDataOut(rxDataOut), .rxDataOe_n(rxDataOe_n), .rxSocIn(rxSocIn), .rxSocOut(rxSocOut),
    .rxSocOe_n(rxSocOe_n), .txData(txData), .txSoc(txSoc), .rxDv(rxDv), .rxEr(rxEr),
    .carrierSense(carrierSense), .miiBrokenHeader(miiBrokenHeader), .miiRxError(miiRxError),
    .masterCellDone(masterCellDone), .masterSocError(masterSocError), .masterPhy(masterPhy),
    .dmaActive(dmaActive), .dmaSubBlock(dmaSubBlock), .dmaReceive(dmaReceive), .dmaError(dmaError),
    .dmaRequesterNumber(dmaRequesterNumber), .dmaErrorRecord(dmaErrorRecord));
  ucp_far_phy ucp_far_phy_inst (.linkClk(linkClk), .enable_n(rxEnableIn_n), .offer(offer), .phy(phy),
    .badSoc(badSoc), .mii(mii), .clav0(farClav), .polled(polledPhyCellReady), .data(farData),
    .soc(farSoc), .crs(carrierSense), .dv(rxDv), .er(rxEr));

  always #50 clk = ~clk;
  always #80 linkClk = ~linkClk;

  function automatic logic [7:0] idle_octet(input int i);
    return i == 3 ? 8'h01 : i == 4 ? 8'h52 : i < 3 ? 8'h00 : 8'h6A;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clk);
    reset_n <= 1'b0;
    mode <= m;
    @(posedge linkClk);
    linkReset_n <= 1'b0;
    repeat (3) @(posedge linkClk);
    // every pin driver released in reset
    check({rxEnableOut_n, rxEnableOe_n, rxClavOe_n, rxDataOe_n, rxSocOe_n, txSoc}, 8'h3E, "reset pins");
    linkReset_n <= 1'b1;
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge linkClk);
  endtask

  task automatic send(input logic [7:0] b, input logic t);
    int k;
    @(posedge clk);
    cellByte <= b;
    cellToTransmit <= t;
    cellByteValid <= 1'b1;
    for (k = 0; k < 300; k++)
    begin
      @(posedge clk);
      if (cellByteReady === 1'b1) break;
    end
    check(8'(k < 300), 8'h01, "octet taken");
    cellByteValid <= 1'b0;
  endtask

  task automatic check_tx(input string what);
    int k;
    for (k = 0; k < 400; k++)
    begin
      @(negedge linkClk);
      if (txSoc === 1'b1 && txData === cellBuf[0]) break;
    end
    check(8'(k < 400), 8'h01, "tx cell start");
    for (int i = 1; i < 53; i++)
    begin
      @(negedge linkClk);
      check(txData, cellBuf[i], what);
      check(8'(txSoc), 8'h00, "tx soc inside cell");
    end
    @(negedge linkClk);
    check(8'(txSoc), 8'h01, "tx soc after 53");
  endtask

  task automatic master(input logic [1:0] p, input logic bad);
    int k;
    @(posedge linkClk);
    phy <= p;
    badSoc <= bad;
    offer <= 1'b1;
    for (k = 0; k < 600; k++)
    begin
      @(posedge clk);
      if (masterCellDone === 1'b1) break;
    end
    @(negedge clk);
    check({k < 600, 4'h0, masterSocError, masterPhy}, {5'h10, bad, p}, "master cell");
    @(posedge linkClk);
    offer <= 1'b0;
  endtask

  initial
  begin
    int k;
    void'($urandom(32'hb4aa));
    lastErr = 6'h00;
    do_reset(UCP_MODE_SLAVE);
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk);
      dmaActive <= 1'b1;
      dmaSubBlock <= i == 0 ? 5'h1F : 5'($urandom);
      dmaReceive <= i[0];
      dmaError <= $urandom % 3 == 0;
      @(posedge clk);
      dmaActive <= 1'b0;
      if (dmaError)
      begin
        lastErr = {dmaReceive, dmaSubBlock};
      end
      @(negedge clk);
      check(8'(dmaRequesterNumber), {2'h0, dmaReceive, dmaSubBlock}, "requester");
      check(8'(dmaErrorRecord), 8'(lastErr), "error record");
    end
    for (int i = 0; i < 53; i++) cellBuf[i] = idle_octet(i);
    check_tx("idle octet");
    // enable with nothing held must leave the lanes floated
    @(posedge linkClk);
    tbEnable_n <= 1'b0;
    repeat (2) @(negedge linkClk);
    check({7'h00, rxDataOe_n}, 8'h01, "refused enable");
    @(posedge linkClk);
    tbEnable_n <= 1'b1;
    for (int i = 0; i < 53; i++) cellBuf[i] = 8'($urandom);
    cellBuf[0] = 8'h80;
    cellBuf[52] = 8'h01;
    for (int i = 0; i < 53; i++) send(cellBuf[i], 1'b0);
    for (k = 0; k < 200; k++)
    begin
      @(negedge linkClk);
      if (rxClavOut === 1'b1) break;
    end
    check({7'h00, rxClavOut}, 8'h01, "cell available");
    @(posedge linkClk);
    tbEnable_n <= 1'b0;
    for (int i = 0; i < 53; i++)
    begin
      @(posedge linkClk);
      if (i == 52) tbEnable_n <= 1'b1;
      @(negedge linkClk);
      check(rxDataOut, cellBuf[i], "rx octet");
      check({rxSocOut, rxDataOe_n, rxSocOe_n, rxClavOut}, {1'(i == 0), 3'b000}, "rx pins");
    end
    @(negedge linkClk);
    check({6'h00, rxDataOe_n, rxSocOe_n}, 8'h03, "rx float after");
    for (int i = 0; i < 53; i++) cellBuf[i] = 8'($urandom);
    cellBuf[0] = 8'hA5;
    for (int i = 0; i < 53; i++) send(cellBuf[i], 1'b1);
    check_tx("tx octet");
    do_reset(UCP_MODE_MII);
    for (int c = 0; c < 8; c++)
    begin
      @(posedge linkClk);
      mii <= 3'(c);
      repeat (6) @(posedge linkClk);
      @(negedge clk);
      check({miiBrokenHeader, miiRxError}, {c[2] && !c[1], c[1] && c[0]}, "mii flags");
    end
    do_reset(UCP_MODE_MASTER);
    master(2'h0, 1'b0);
    master(2'h0, 1'b1);
    do_reset(UCP_MODE_MULTI_PHY);
    for (int p = 0; p < 4; p++) master(2'(p), 1'($urandom));
    tally_and_finish();
  end

  initial
  begin
    #3_000_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
